// >>> pkg/pmbus_status_defs.vh
// command codes, field positions and reset values of the status and telemetry registers
//
// Operation
// RULE1 - output-current byte: bit7 overcurrent, 6 overcurrent low voltage, 5 warning, 4 undercurrent
// RULE2 - output-current byte is read-only, kept per page, resets to zero
// RULE3 - input byte: bit7 ov fault, 6 ov warning, 5 uv warning, 4 uv fault
// RULE4 - input byte is one global read-only byte shared by pages, resets zero
// RULE5 - temperature byte: bit7 ot fault, 6 ot warning, 5 ut warning, 4 ut fault
// RULE6 - temperature byte is read-only, kept per page, resets to zero
// RULE7 - comm byte bit7 flags invalid command code; global, read-only, resets zero
// RULE8 - comm byte bit6 flags a command carrying invalid or unsupported data
// RULE9 - comm byte bit5 flags a packet error in a received command
// RULE10 - comm byte bit1 flags writes to read-only commands or other faults
// RULE11 - vendor byte bit3 flags loss of external clock synchronisation
// RULE12 - vendor byte bit1 monitor undervoltage fault, bit0 monitor overvoltage fault
// RULE13 - vendor byte bit5 when monitor voltage below 1.1 times undervoltage limit
// RULE14 - vendor byte bit4 when monitor voltage above 0.9 times overvoltage limit
// RULE15 - vendor byte is global, read-only, resets zero, bits 7, 6, 2 unused
// RULE16 - input-voltage reading is a global read-only two-byte value
// RULE17 - reading uses signed exponent in bits 15:11, signed mantissa in 10:0
// RULE18 - summary word bit1 set while any comm byte flag is set
// RULE19 - summary word bit12 set while any vendor byte flag is set
// RULE20 - flags stay latched until the host clears faults
// RULE21 - host reads by command code, selecting the page first for paged ones
`ifndef PMBUS_STATUS_DEFS_VH
`define PMBUS_STATUS_DEFS_VH

// command codes
`define CMD_OUTPUT_CURRENT_FLAGS 8'h7b
`define CMD_INPUT_FLAGS 8'h7c
`define CMD_TEMPERATURE_FLAGS 8'h7d
`define CMD_COMM_FLAGS 8'h7e
`define CMD_VENDOR_FLAGS 8'h80
`define CMD_INPUT_VOLTAGE_READING 8'h88

// reset values
`define FLAGS_RESET 8'h00
`define READING_RESET 16'h0000

// shared layout of the four-flag bytes (current, input, temperature)
`define FLAG4_LSB 4
`define FLAG4_MSB 7

// comm byte fields
`define COMM_BAD_CMD_BIT 7
`define COMM_BAD_DATA_BIT 6
`define COMM_PEC_BIT 5
`define COMM_OTHER_BIT 1

// vendor byte fields
`define VENDOR_MON_UV_WARN_BIT 5
`define VENDOR_MON_OV_WARN_BIT 4
`define VENDOR_SYNC_LOST_BIT 3
`define VENDOR_MON_UV_FAULT_BIT 1
`define VENDOR_MON_OV_FAULT_BIT 0

// warning thresholds as ratios in tenths: 11/10 and 9/10
`define MON_UV_WARN_NUM 4'hb
`define MON_OV_WARN_NUM 4'h9
`define MON_RATIO_DEN 4'ha

// linear-11 fields
`define LIN_EXP_MSB 15
`define LIN_EXP_LSB 11
`define LIN_MANT_MSB 10

`endif

// >>> verilog/sticky_flags.v
// latched flag group: hardware sets, a clear pulse resets, set beats clear
`timescale 1ns/1ps
module sticky_flags #(
   parameter W = 4
) (
   input wire ref_clk,
   input wire reset_n,
   input wire [W-1:0] set,
   input wire clear,
   output reg [W-1:0] flags
);

   // a set arriving with the clear survives so no event is lost
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         flags <= {W{1'b0}};
      end else if (clear) begin
         flags <= set; // RULE20
      end else begin
         flags <= flags | set; // RULE20
      end
   end

endmodule

// >>> verilog/linear11_encoder.v
// unsigned raw reading to linear-11 word, mantissa shifted right only until it fits ten bits
`timescale 1ns/1ps
module linear11_encoder #(
   parameter RAW_W = 16,
   parameter [4:0] BASE_EXP = 5'h18
) (
   input wire [RAW_W-1:0] raw,
   output reg [15:0] word
);

   reg [RAW_W-1:0] mag;
   reg [4:0] shifts;
   integer i;

   // shift right until the value fits a positive mantissa; low bits are truncated
   always @* begin
      mag = raw;
      shifts = 5'h00;
      for (i = 0; i < RAW_W; i = i + 1) begin
         if (mag > 1023) begin
            mag = mag >> 1;
            shifts = shifts + 5'h01;
         end
      end
      word = {BASE_EXP + shifts, 1'b0, mag[9:0]}; // RULE17
   end

endmodule

// >>> verilog/pmbus_status_regs.v
// read-only status bytes and input-voltage reading answered by command code
`timescale 1ns/1ps
`include "pmbus_status_defs.vh"
module pmbus_status_regs #(
   parameter NUM_PAGES = 2,
   parameter PAGE_W = 1,
   parameter MON_W = 12,
   parameter VIN_W = 16,
   parameter [4:0] VIN_BASE_EXP = 5'h18
) (
   input wire ref_clk,
   input wire reset_n,
   input wire [PAGE_W-1:0] page_sel,
   input wire rd_req,
   input wire [7:0] rd_cmd,
   input wire wr_req,
   input wire [7:0] wr_cmd,
   input wire err_bad_cmd,
   input wire err_bad_data,
   input wire err_pec,
   input wire err_other,
   input wire clear_faults,
   input wire [NUM_PAGES*4-1:0] iout_cond,
   input wire [NUM_PAGES*4-1:0] temp_cond,
   input wire [3:0] input_cond,
   input wire ext_sync_lost,
   input wire mon_valid,
   input wire [MON_W-1:0] monitor_input_voltage,
   input wire [MON_W-1:0] monitor_undervoltage_fault_limit,
   input wire [MON_W-1:0] monitor_overvoltage_fault_limit,
   input wire vin_valid,
   input wire [VIN_W-1:0] vin_raw,
   output reg rd_valid,
   output reg [15:0] rd_data,
   output reg rd_word,
   output reg rd_miss,
   output reg comm_logic_memory_fault,
   output reg vendor_specific_summary
);

   // ----------------------------------------------------------------
   // paged flag bytes
   // ----------------------------------------------------------------

   wire [NUM_PAGES*4-1:0] iout_flags;
   wire [NUM_PAGES*4-1:0] temp_flags;

   // one latch group per page for current and temperature, so each
   // output keeps its own history independent of the page selected
   genvar g;
   generate
      for (g = 0; g < NUM_PAGES; g = g + 1) begin : page
         sticky_flags #(
            .W(4)
         ) iout_latch (
            .ref_clk(ref_clk),
            .reset_n(reset_n),
            .set(iout_cond[g*4 +: 4]), // RULE1
            .clear(clear_faults),
            .flags(iout_flags[g*4 +: 4]) // RULE2
         );
         sticky_flags #(
            .W(4)
         ) temp_latch (
            .ref_clk(ref_clk),
            .reset_n(reset_n),
            .set(temp_cond[g*4 +: 4]), // RULE5
            .clear(clear_faults),
            .flags(temp_flags[g*4 +: 4]) // RULE6
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // global input flag byte
   // ----------------------------------------------------------------

   wire [3:0] input_flags;

   // input_cond order is {ov fault, ov warning, uv warning, uv fault}
   sticky_flags #(
      .W(4)
   ) input_latch (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .set(input_cond), // RULE3
      .clear(clear_faults),
      .flags(input_flags) // RULE4
   );

   // ----------------------------------------------------------------
   // communication, logic and memory flag byte
   // ----------------------------------------------------------------

   reg wr_to_readonly;
   wire [7:0] comm_set;
   wire [7:0] comm_flags;

   // every command this block owns is read-only, so any write to one is refused;
   // writes to other codes belong to the protocol engine and are left alone here
   always @* begin
      wr_to_readonly = 1'b0;
      if (wr_req) begin
         if (wr_cmd == `CMD_OUTPUT_CURRENT_FLAGS) begin
            wr_to_readonly = 1'b1;
         end else if (wr_cmd == `CMD_INPUT_FLAGS) begin
            wr_to_readonly = 1'b1;
         end else if (wr_cmd == `CMD_TEMPERATURE_FLAGS) begin
            wr_to_readonly = 1'b1;
         end else if (wr_cmd == `CMD_COMM_FLAGS) begin
            wr_to_readonly = 1'b1;
         end else if (wr_cmd == `CMD_VENDOR_FLAGS) begin
            wr_to_readonly = 1'b1;
         end else if (wr_cmd == `CMD_INPUT_VOLTAGE_READING) begin
            wr_to_readonly = 1'b1;
         end
      end
   end

   // unused bits 4:2 and 0 are never set
   assign comm_set[`COMM_BAD_CMD_BIT] = err_bad_cmd; // RULE7
   assign comm_set[`COMM_BAD_DATA_BIT] = err_bad_data; // RULE8
   assign comm_set[`COMM_PEC_BIT] = err_pec; // RULE9
   assign comm_set[4:2] = 3'h0;
   assign comm_set[`COMM_OTHER_BIT] = wr_to_readonly | err_other; // RULE10
   assign comm_set[0] = 1'b0;

   sticky_flags #(
      .W(8)
   ) comm_latch (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .set(comm_set),
      .clear(clear_faults),
      .flags(comm_flags) // RULE7
   );

   // ----------------------------------------------------------------
   // monitor-input comparisons
   // ----------------------------------------------------------------

   // compare in tenths (10*v against 11*limit or 9*limit) so the derived
   // warning thresholds are exact without a divider
   wire [MON_W+3:0] mon_x10;
   wire [MON_W+3:0] uv_x10;
   wire [MON_W+3:0] ov_x10;
   wire [MON_W+3:0] uv_warn_x10;
   wire [MON_W+3:0] ov_warn_x10;

   assign mon_x10 = {4'h0, monitor_input_voltage} * `MON_RATIO_DEN;
   assign uv_x10 = {4'h0, monitor_undervoltage_fault_limit} * `MON_RATIO_DEN;
   assign ov_x10 = {4'h0, monitor_overvoltage_fault_limit} * `MON_RATIO_DEN;
   assign uv_warn_x10 = {4'h0, monitor_undervoltage_fault_limit} * `MON_UV_WARN_NUM;
   assign ov_warn_x10 = {4'h0, monitor_overvoltage_fault_limit} * `MON_OV_WARN_NUM;

   wire mon_uv_fault;
   wire mon_ov_fault;
   wire mon_uv_warn;
   wire mon_ov_warn;

   // comparisons count only on a fresh monitor sample
   assign mon_uv_fault = mon_valid & (mon_x10 < uv_x10); // RULE12
   assign mon_ov_fault = mon_valid & (mon_x10 > ov_x10); // RULE12
   assign mon_uv_warn = mon_valid & (mon_x10 < uv_warn_x10); // RULE13
   assign mon_ov_warn = mon_valid & (mon_x10 > ov_warn_x10); // RULE14

   // ----------------------------------------------------------------
   // vendor-specific flag byte
   // ----------------------------------------------------------------

   wire [7:0] vendor_set;
   wire [7:0] vendor_flags;

   // bits 7, 6 and 2 stay zero
   assign vendor_set[7:6] = 2'h0; // RULE15
   assign vendor_set[`VENDOR_MON_UV_WARN_BIT] = mon_uv_warn; // RULE13
   assign vendor_set[`VENDOR_MON_OV_WARN_BIT] = mon_ov_warn; // RULE14
   assign vendor_set[`VENDOR_SYNC_LOST_BIT] = ext_sync_lost; // RULE11
   assign vendor_set[2] = 1'b0; // RULE15
   assign vendor_set[`VENDOR_MON_UV_FAULT_BIT] = mon_uv_fault; // RULE12
   assign vendor_set[`VENDOR_MON_OV_FAULT_BIT] = mon_ov_fault; // RULE12

   sticky_flags #(
      .W(8)
   ) vendor_latch (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .set(vendor_set),
      .clear(clear_faults),
      .flags(vendor_flags) // RULE15
   );

   // ----------------------------------------------------------------
   // input-voltage reading
   // ----------------------------------------------------------------

   wire [15:0] vin_encoded;
   reg [15:0] vin_reading;

   linear11_encoder #(
      .RAW_W(VIN_W),
      .BASE_EXP(VIN_BASE_EXP)
   ) vin_encoder (
      .raw(vin_raw),
      .word(vin_encoded) // RULE17
   );

   // the reading holds the last sample; a host read never sees a half update
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         vin_reading <= `READING_RESET;
      end else if (vin_valid) begin
         vin_reading <= vin_encoded; // RULE16
      end
   end

   // ----------------------------------------------------------------
   // page selection of the paged bytes
   // ----------------------------------------------------------------

   reg [3:0] iout_sel;
   reg [3:0] temp_sel;
   integer p;

   // a page beyond the last output reads as zero; page_sel only matters
   // in the cycle of the request, so a page change between reads is harmless
   always @* begin
      iout_sel = 4'h0;
      temp_sel = 4'h0;
      for (p = 0; p < NUM_PAGES; p = p + 1) begin
         if (page_sel == p[PAGE_W-1:0]) begin
            iout_sel = iout_flags[p*4 +: 4]; // RULE2
            temp_sel = temp_flags[p*4 +: 4]; // RULE6
         end
      end
   end

   // ----------------------------------------------------------------
   // read decode
   // ----------------------------------------------------------------

   reg [15:0] next_rd_data;
   reg next_rd_word;
   reg next_rd_miss;

   // byte registers sit in the low byte; the upper byte reads zero
   always @* begin
      next_rd_data = 16'h0000;
      next_rd_word = 1'b0;
      next_rd_miss = 1'b0;
      if (rd_cmd == `CMD_OUTPUT_CURRENT_FLAGS) begin
         next_rd_data = {8'h00, iout_sel, 4'h0}; // RULE1
      end else if (rd_cmd == `CMD_INPUT_FLAGS) begin
         next_rd_data = {8'h00, input_flags, 4'h0}; // RULE3
      end else if (rd_cmd == `CMD_TEMPERATURE_FLAGS) begin
         next_rd_data = {8'h00, temp_sel, 4'h0}; // RULE5
      end else if (rd_cmd == `CMD_COMM_FLAGS) begin
         next_rd_data = {8'h00, comm_flags}; // RULE7
      end else if (rd_cmd == `CMD_VENDOR_FLAGS) begin
         next_rd_data = {8'h00, vendor_flags}; // RULE15
      end else if (rd_cmd == `CMD_INPUT_VOLTAGE_READING) begin
         next_rd_data = vin_reading; // RULE16
         next_rd_word = 1'b1; // RULE16
      end else begin
         next_rd_miss = 1'b1;
      end
   end

   // answer one cycle after the request; data hold until the next read
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rd_valid <= 1'b0;
         rd_data <= 16'h0000;
         rd_word <= 1'b0;
         rd_miss <= 1'b0;
      end else begin
         rd_valid <= rd_req;
         if (rd_req) begin
            rd_data <= next_rd_data;
            rd_word <= next_rd_word;
            rd_miss <= next_rd_miss;
         end
      end
   end

   // ----------------------------------------------------------------
   // summary word bits
   // ----------------------------------------------------------------

   // registered copies lag the flag bytes by one cycle
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         comm_logic_memory_fault <= 1'b0;
         vendor_specific_summary <= 1'b0;
      end else begin
         comm_logic_memory_fault <= |comm_flags; // RULE18
         vendor_specific_summary <= |vendor_flags; // RULE19
      end
   end

endmodule

// >>> verif/pmbus_status_chk.sv
// concurrent checks on the status read port and summary outputs
`timescale 1ns/1ps
module pmbus_status_chk (
   input wire ref_clk,
   input wire reset_n,
   input wire rd_req,
   input wire [7:0] rd_cmd,
   input wire err_pec,
   input wire ext_sync_lost,
   input wire clear_faults,
   input wire rd_valid,
   input wire [15:0] rd_data,
   input wire rd_word,
   input wire rd_miss,
   input wire comm_logic_memory_fault,
   input wire vendor_specific_summary
);
   // ----------
   // properties
   // ----------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   wire cmd_known = rd_cmd inside {8'h7b, 8'h7c, 8'h7d, 8'h7e, 8'h80, 8'h88};
   // a read taken with one code
   sequence s_rd(c);
      rd_req && rd_cmd == c;
   endsequence
   AST_ANSWER: assert property (rd_req |=> rd_valid)
      else $error("read not answered");
   AST_QUIET: assert property (!rd_req |=> !rd_valid)
      else $error("answer without read");
   AST_STAND: assert property (!rd_req |=> $stable(rd_data) && $stable(rd_word))
      else $error("answer moved without read");
   AST_MISS: assert property (rd_req && !cmd_known |=> rd_miss && rd_data == 16'h0000)
      else $error("unknown code not a miss");
   AST_WORD: assert property (s_rd(8'h88) |=> rd_word && !rd_miss && !rd_data[10])
      else $error("reading not a word");
   AST_FOUR: assert property ((s_rd(8'h7b) or s_rd(8'h7c) or s_rd(8'h7d))
      |=> rd_data[15:8] == 8'h00 && rd_data[3:0] == 4'h0 && !rd_word)
      else $error("unused flag bits set");
   AST_COMM: assert property (s_rd(8'h7e) |=> rd_data[15:8] == 8'h00
      && rd_data[4:2] == 3'h0 && !rd_data[0])
      else $error("unused comm bits set");
   AST_VENDOR: assert property (s_rd(8'h80) |=> rd_data[15:6] == 10'h000 && !rd_data[2])
      else $error("unused vendor bits set");
   AST_PEC_SUM: assert property (err_pec |-> ##2 comm_logic_memory_fault)
      else $error("comm summary late");
   AST_SYNC_SUM: assert property (ext_sync_lost |-> ##2 vendor_specific_summary)
      else $error("vendor summary late");
   AST_HOLD: assert property ($fell(comm_logic_memory_fault) |-> $past(clear_faults, 2))
      else $error("comm summary dropped without clear");
endmodule

// >>> verif/pmbus_host_model.sv
// behavioural host issuing command-code reads
`timescale 1ns/1ps
module pmbus_host_model (
   input wire ref_clk,
   input wire rd_valid,
   input wire [15:0] rd_data,
   input wire rd_word,
   input wire rd_miss,
   output reg rd_req,
   output reg [7:0] rd_cmd,
   output reg [0:0] page_sel
);
   // ----------
   // read cycle
   // ----------
   initial begin
      rd_req = 1'b0;
      rd_cmd = 8'h00;
      page_sel = 1'b0;
   end
   // page goes with the code, so paged reads never see a stale page
   task read(input [7:0] cmd, input [0:0] page, input integer gap, output [17:0] ans);
      integer i;
      begin
         for (i = 0; i < gap; i = i + 1) @(posedge ref_clk);
         @(posedge ref_clk);
         #1;
         rd_req = 1'b1;
         rd_cmd = cmd;
         page_sel = page;
         @(posedge ref_clk);
         #1;
         ans = rd_valid ? {rd_miss, rd_word, rd_data} : 18'h3ffff;
         rd_req = 1'b0;
         rd_cmd = ~cmd; // released lines must not keep the last value
         page_sel = ~page;
      end
   endtask
endmodule

// >>> verif/pmbus_status_regs_bench.sv
// self-checking bench for the status registers
`timescale 1ns/1ps
module pmbus_status_regs_bench;
   // -----
   // setup
   // -----
   reg ref_clk = 1'b0;
   reg reset_n = 1'b0;
   reg wr_req = 1'b0, err_bad_cmd = 1'b0, err_bad_data = 1'b0, err_pec = 1'b0;
   reg err_other = 1'b0, clear_faults = 1'b0, ext_sync_lost = 1'b0;
   reg mon_valid = 1'b0, vin_valid = 1'b0;
   reg [7:0] wr_cmd = 8'h00, iout_cond = 8'h00, temp_cond = 8'h00;
   reg [3:0] input_cond = 4'h0;
   reg [11:0] mon_v = 12'h096, uv_lim = 12'h064, ov_lim = 12'h0c8;
   reg [15:0] vin_raw = 16'h0000;
   wire rd_req, rd_valid, rd_word, rd_miss, comm_sum, vend_sum;
   wire [7:0] rd_cmd;
   wire [0:0] page_sel;
   wire [15:0] rd_data;
   integer miscompares = 0, tests_run = 0, k;
   reg [17:0] ans;
   // monitor codes around limits 100 and 200, strict compares at the edges
   reg [11:0] mvs [0:5] = '{12'h069, 12'h05f, 12'h0b9, 12'h0cd, 12'h06e, 12'h0b4};
   reg [7:0] mexp [0:5] = '{8'h20, 8'h22, 8'h10, 8'h11, 8'h00, 8'h00};
   always #50 ref_clk = ~ref_clk;
   pmbus_status_regs pmbus_status_regs_inst (.ref_clk(ref_clk), .reset_n(reset_n),
      .page_sel(page_sel), .rd_req(rd_req), .rd_cmd(rd_cmd), .wr_req(wr_req), .wr_cmd(wr_cmd),
      .err_bad_cmd(err_bad_cmd), .err_bad_data(err_bad_data), .err_pec(err_pec),
      .err_other(err_other), .clear_faults(clear_faults), .iout_cond(iout_cond),
      .temp_cond(temp_cond), .input_cond(input_cond), .ext_sync_lost(ext_sync_lost),
      .mon_valid(mon_valid), .monitor_input_voltage(mon_v),
      .monitor_undervoltage_fault_limit(uv_lim), .monitor_overvoltage_fault_limit(ov_lim),
      .vin_valid(vin_valid), .vin_raw(vin_raw), .rd_valid(rd_valid), .rd_data(rd_data),
      .rd_word(rd_word), .rd_miss(rd_miss), .comm_logic_memory_fault(comm_sum),
      .vendor_specific_summary(vend_sum));
   pmbus_host_model host_inst (.ref_clk(ref_clk), .rd_valid(rd_valid), .rd_data(rd_data),
      .rd_word(rd_word), .rd_miss(rd_miss), .rd_req(rd_req), .rd_cmd(rd_cmd),
      .page_sel(page_sel));
   task step;
      begin
         @(posedge ref_clk);
         #1;
      end
   endtask
   task check(input [17:0] seen, input [17:0] exp);
      begin
         tests_run = tests_run + 1;
         if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
         end
      end
   endtask
   // miss, word and data compared together
   task rc(input [7:0] cmd, input integer page, input [15:0] exp);
      reg known;
      begin
         known = cmd inside {8'h7b, 8'h7c, 8'h7d, 8'h7e, 8'h80, 8'h88};
         host_inst.read(cmd, page[0:0], 0, ans);
         check(ans, {!known, cmd == 8'h88, exp});
      end
   endtask
   task clr;
      begin
         clear_faults = 1'b1;
         step;
         clear_faults = 1'b0;
         step;
      end
   endtask
   task tally_and_finish;
      begin
         if (miscompares == 0 && tests_run > 0)
            $display("Result: passed");
         else
            $display("Result: failed");
         $finish;
      end
   endtask
   initial begin
      #1000000;
      miscompares = miscompares + 1;
      tally_and_finish;
   end
   // -----
   // tests
   // -----
   initial begin
      repeat (20) @(posedge ref_clk);
      #1;
      reset_n = 1'b1;
      for (k = 0; k < 2; k = k + 1) begin
         rc(8'h7b, k, 16'h0000);
         rc(8'h7c, k, 16'h0000);
         rc(8'h7d, k, 16'h0000);
         rc(8'h80, k, 16'h0000);
         rc(8'h88, k, 16'h0000);
      end
      rc(8'h7a, 0, 16'h0000);
      rc(8'h7e, 0, 16'h0000);
      // one-cycle conditions: page 1 current, page 0 temperature, shared input
      iout_cond = 8'ha0;
      temp_cond = 8'h05;
      input_cond = 4'hf;
      step;
      iout_cond = 8'h00;
      temp_cond = 8'h00;
      input_cond = 4'h0;
      rc(8'h7b, 1, 16'h00a0);
      rc(8'h7b, 0, 16'h0000);
      rc(8'h7d, 0, 16'h0050);
      rc(8'h7d, 1, 16'h0000);
      rc(8'h7c, 1, 16'h00f0);
      rc(8'h7c, 0, 16'h00f0);
      host_inst.read(8'h7b, 1'b1, 3, ans);
      check(ans, {2'b00, 16'h00a0});
      clr;
      rc(8'h7b, 1, 16'h0000);
      // comm flags build up one by one
      err_bad_cmd = 1'b1;
      step;
      err_bad_cmd = 1'b0;
      rc(8'h7e, 0, 16'h0080);
      err_bad_data = 1'b1;
      step;
      err_bad_data = 1'b0;
      rc(8'h7e, 0, 16'h00c0);
      err_pec = 1'b1;
      step;
      err_pec = 1'b0;
      step;
      check({17'h0, comm_sum}, 18'h1);
      rc(8'h7e, 0, 16'h00e0);
      err_other = 1'b1;
      step;
      err_other = 1'b0;
      rc(8'h7e, 1, 16'h00e2);
      clr;
      check({17'h0, comm_sum}, 18'h0);
      wr_cmd = 8'h01;
      wr_req = 1'b1;
      step;
      wr_req = 1'b0;
      rc(8'h7e, 0, 16'h0000);
      wr_cmd = 8'h88;
      wr_req = 1'b1;
      step;
      wr_req = 1'b0;
      rc(8'h7e, 0, 16'h0002);
      // a set in the clearing cycle must survive
      err_pec = 1'b1;
      clear_faults = 1'b1;
      step;
      err_pec = 1'b0;
      clear_faults = 1'b0;
      rc(8'h7e, 0, 16'h0020);
      clr;
      // unqualified zero code must not raise the undervoltage fault
      for (k = 0; k < 6; k = k + 1) begin
         mon_v = mvs[k];
         mon_valid = 1'b1;
         step;
         mon_valid = 1'b0;
         mon_v = 12'h000;
         rc(8'h80, 0, {8'h00, mexp[k]});
         clr;
      end
      ext_sync_lost = 1'b1;
      step;
      ext_sync_lost = 1'b0;
      step;
      check({17'h0, vend_sum}, 18'h1);
      rc(8'h80, 0, 16'h0008);
      clr;
      check({17'h0, vend_sum}, 18'h0);
      // raw 12288 needs four shifts, raw 341 none
      vin_raw = 16'h3000;
      vin_valid = 1'b1;
      step;
      vin_valid = 1'b0;
      vin_raw = 16'h0155;
      rc(8'h88, 1, 16'he300);
      vin_valid = 1'b1;
      step;
      vin_valid = 1'b0;
      rc(8'h88, 0, 16'hc155);
      tally_and_finish;
   end
endmodule
bind pmbus_status_regs pmbus_status_chk pmbus_status_chk_inst (.ref_clk(ref_clk),
   .reset_n(reset_n), .rd_req(rd_req), .rd_cmd(rd_cmd), .err_pec(err_pec),
   .ext_sync_lost(ext_sync_lost), .clear_faults(clear_faults), .rd_valid(rd_valid),
   .rd_data(rd_data), .rd_word(rd_word), .rd_miss(rd_miss),
   .comm_logic_memory_fault(comm_logic_memory_fault),
   .vendor_specific_summary(vendor_specific_summary));
